// >>> src/tpf_pkg.sv
// Package for the timer/PWM interrupt flag block
package tpf_pkg;
    // Register offsets (word index on the plain register port)
    localparam logic [3:0] OFS_STATUS_CONTROL = 4'h0;
    localparam logic [3:0] OFS_MODULO = 4'h1;
    localparam logic [3:0] OFS_COUNT = 4'h2;
    localparam logic [3:0] OFS_FLAGS = 4'h3;
    localparam logic [3:0] OFS_CH_CTRL = 4'h4;
    localparam logic [3:0] OFS_CH_VALUE = 4'h8;
    localparam logic [3:0] OFS_IRQ_STATUS = 4'hC;
    localparam logic [3:0] OFS_IRQ_CLEAR = 4'hD;
    localparam logic [3:0] OFS_IRQ_ENABLE = 4'hE;
    // Field positions in the status/control register
    localparam int SC_RUN_BIT = 0;
    localparam int SC_CENTER_BIT = 1;
    localparam int SC_OVF_IE_BIT = 2;
    localparam int SC_OVF_FLAG_BIT = 7;
    // Field positions in a channel control register
    localparam int CC_ELS_LO_BIT = 0;
    localparam int CC_ELS_HI_BIT = 1;
    localparam int CC_MODE_BIT = 2;
    localparam int CC_IE_BIT = 3;
    localparam int CC_FLAG_BIT = 7;
    // Reset values and the free-running terminal count
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [15:0] MODULO_RESET = 16'h0000;
    localparam logic [15:0] COUNT_TOP = 16'hFFFF;
    localparam logic [7:0] CTRL_RESET = 8'h00;

    // One register port access
    typedef struct packed {
        logic wr;
        logic rd;
        logic [3:0] addr;
        logic [15:0] wdata;
    } tpf_bus_s;

    // Events detected in one cycle
    typedef struct packed {
        logic ovf;
        logic [3:0] ch;
    } tpf_evt_s;

    // Counter direction
    typedef enum logic {TPF_UP, TPF_DOWN} tpf_dir_e;
endpackage

// >>> src/tpf_timer_flags.sv
// Timer/PWM counter with overflow and channel event flags and interrupt request
// Operation
// - Overflow flag sets when counter leaves terminal count for next value.
// - Channel flag sets on every capture or compare event of that channel.
// - Interrupt request is an active-high output; vectors lie elsewhere.
// - Enabled flag raises level request while set; disabled flag only polls.
// - Flag clears only after read while set then write of zero.
// - New event between read and zero write restarts clearing; flag stays.
// - Up mode: overflow flag sets on wrap modulo to zero (free-run FFFF).
// - Center mode: overflow flag sets at turn from up to down at modulo.
// - Capture edge select picks none, rising, falling or both edges.
// - Output compare sets flag whenever the running counter equals 16-bit channel value.
// - Edge PWM sets flag at counter match ending active duty.
// - Center PWM sets flag on match counting up and counting down.
// - Center select makes counter run up to modulo then down to zero.
// - Reset clears status/control: counter stopped, overflow enable zero.
//
// Our own choices: strobed register access and the register addresses.
module tpf_timer_flags
    import tpf_pkg::*;
#(
    parameter int NUM_CH = 4
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Register port
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // Capture pins, asynchronous
    input wire logic [NUM_CH-1:0] capture_pin,
    // Interrupt request to the chip interrupt module
    output logic irq
);

    // Register map, one 16-bit word per index:
    //   0 status/control: run, center select, overflow enable, overflow flag
    //   1 modulo; zero lets the counter run free up to FFFF
    //   2 counter; any write restarts it from zero counting up
    //   4 to 7 channel control: edge selects, compare mode, enable, event flag
    //   8 to B channel compare value
    //   3 and C to F read as zero and ignore writes
    // Channel values are plain storage: a capture sets the flag but does not latch the count.

    // Channel events are packed into a fixed structure sized for four channels
    if (NUM_CH != 4) begin : g_num_ch_check
        $error("tpf_timer_flags supports exactly four channels");
    end

    // Bundle the port so every decode below reads one carrier
    tpf_bus_s bus;
    assign bus = '{wr: reg_wr, rd: reg_rd, addr: reg_addr, wdata: reg_wdata};

    // Address decode shared by read and write paths
    function automatic logic is_ch(input logic [3:0] a, input logic [3:0] base,
                                   input int n);
        is_ch = (a == base + 4'(n));
    endfunction

    // Control state
    logic run_q;
    logic center_aligned_select_q;
    logic overflow_irq_enable_q;
    logic [15:0] modulo_q;
    // Counter and its direction
    logic [15:0] count_q;
    tpf_dir_e dir_q;
    // Channel configuration
    logic [NUM_CH-1:0] edge_level_select_lo_q;
    logic [NUM_CH-1:0] edge_level_select_hi_q;
    logic [NUM_CH-1:0] compare_mode_q;
    logic [NUM_CH-1:0] channel_irq_enable_q;
    logic [15:0] ch_value_q [NUM_CH];
    // Flags and the arms of their two-step clear
    logic overflow_flag_q;
    logic [NUM_CH-1:0] channel_event_flag_q;
    logic ovf_armed_q;
    logic [NUM_CH-1:0] ch_armed_q;
    // Capture synchroniser and edge detector
    logic [NUM_CH-1:0] cap_meta_q;
    logic [NUM_CH-1:0] cap_sync_q;
    logic [NUM_CH-1:0] cap_prev_q;
    tpf_evt_s evt;

    // Terminal count: modulo zero means free-running to FFFF
    // Center mode with modulo zero would only turn at FFFF; software must avoid it
    logic [15:0] top;
    assign top = (modulo_q == MODULO_RESET) ? COUNT_TOP : modulo_q;

    // Status/control register: reset stops the counter and clears the overflow enable
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            run_q <= 1'b0;
            center_aligned_select_q <= 1'b0;
            overflow_irq_enable_q <= 1'b0;
        end else if (bus.wr && bus.addr == OFS_STATUS_CONTROL) begin
            // The overflow flag bit of this word belongs to the flag process
            run_q <= bus.wdata[SC_RUN_BIT];
            center_aligned_select_q <= bus.wdata[SC_CENTER_BIT];
            overflow_irq_enable_q <= bus.wdata[SC_OVF_IE_BIT];
        end
    end

    // Modulo register
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            modulo_q <= MODULO_RESET;
        end else if (bus.wr && bus.addr == OFS_MODULO) begin
            modulo_q <= bus.wdata;
        end
    end

    // Counter: up only, or up to modulo then down to zero in center mode
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            count_q <= COUNT_RESET;
            dir_q <= TPF_UP;
        end else if (bus.wr && bus.addr == OFS_COUNT) begin
            count_q <= COUNT_RESET; // Any write restarts the count
            dir_q <= TPF_UP;
        end else if (run_q) begin
            if (!center_aligned_select_q) begin
                // Up-only mode wraps from top straight to zero
                dir_q <= TPF_UP;
                count_q <= (count_q == top) ? COUNT_RESET : count_q + 16'h0001;
            end else if (dir_q == TPF_UP) begin
                // At or above top, so a modulo lowered below the count still turns
                if (count_q >= top) begin
                    dir_q <= TPF_DOWN;
                    count_q <= count_q - 16'h0001;
                end else begin
                    count_q <= count_q + 16'h0001;
                end
            end else begin
                if (count_q == COUNT_RESET) begin
                    dir_q <= TPF_UP;
                    count_q <= count_q + 16'h0001;
                end else begin
                    count_q <= count_q - 16'h0001;
                end
            end
        end
    end

    // Channel control and value registers; reset leaves all channels as capture, disabled
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            edge_level_select_lo_q <= '0;
            edge_level_select_hi_q <= '0;
            compare_mode_q <= '0;
            channel_irq_enable_q <= '0;
            for (int i = 0; i < NUM_CH; i++) begin
                ch_value_q[i] <= COUNT_RESET;
            end
        end else if (bus.wr) begin
            for (int i = 0; i < NUM_CH; i++) begin
                if (is_ch(bus.addr, OFS_CH_CTRL, i)) begin
                    // The flag bit of this word belongs to the flag process
                    edge_level_select_lo_q[i] <= bus.wdata[CC_ELS_LO_BIT];
                    edge_level_select_hi_q[i] <= bus.wdata[CC_ELS_HI_BIT];
                    compare_mode_q[i] <= bus.wdata[CC_MODE_BIT];
                    channel_irq_enable_q[i] <= bus.wdata[CC_IE_BIT];
                end
                if (is_ch(bus.addr, OFS_CH_VALUE, i)) begin
                    ch_value_q[i] <= bus.wdata;
                end
            end
        end
    end

    // Capture pins pass two flip-flops before the edge detector
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            // Idle level of the pins is low, so no false edge follows reset
            cap_meta_q <= '0;
            cap_sync_q <= '0;
            cap_prev_q <= '0;
        end else begin
            // Only the second stage reads the first, so no logic sees a settling value
            cap_meta_q <= capture_pin;
            cap_sync_q <= cap_meta_q;
            cap_prev_q <= cap_sync_q;
        end
    end

    // Event detection for the overflow and every channel
    always_comb begin
        logic rise;
        logic fall;
        logic match;
        rise = 1'b0;
        fall = 1'b0;
        match = 1'b0;
        evt = '0;
        if (run_q) begin
            if (!center_aligned_select_q) begin
                evt.ovf = (count_q == top);
            end else begin
                // Center mode: the event is the turn from counting up to down
                evt.ovf = (dir_q == TPF_UP) && (count_q >= top);
            end
        end
        for (int i = 0; i < NUM_CH; i++) begin
            // Edges compare the synchronised level with its one-cycle-old copy
            rise = cap_sync_q[i] && !cap_prev_q[i];
            fall = !cap_sync_q[i] && cap_prev_q[i];
            // Counter value is judged on the cycle it advances, so a stopped timer never matches
            match = run_q && (count_q == ch_value_q[i]);
            if (center_aligned_select_q || compare_mode_q[i]) begin
                evt.ch[i] = match;
            end else begin
                evt.ch[i] = (edge_level_select_lo_q[i] && rise)
                    || (edge_level_select_hi_q[i] && fall);
            end
        end
    end

    // Overflow flag with read-then-write-zero clear; the arm is dropped by a new event
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            overflow_flag_q <= 1'b0;
            ovf_armed_q <= 1'b0;
        end else begin
            // Set wins over a clearing write in the same cycle, so no event is lost
            if (evt.ovf) begin
                overflow_flag_q <= 1'b1;
                ovf_armed_q <= 1'b0;
            end else if (bus.wr && bus.addr == OFS_STATUS_CONTROL
                         && !bus.wdata[SC_OVF_FLAG_BIT] && ovf_armed_q) begin
                overflow_flag_q <= 1'b0;
                ovf_armed_q <= 1'b0;
            // A read of a clear flag does not arm, so a blind zero write is harmless
            end else if (bus.rd && bus.addr == OFS_STATUS_CONTROL && overflow_flag_q) begin
                ovf_armed_q <= 1'b1;
            end
        end
    end

    // Channel flags use the same two-step clear through their control registers
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            channel_event_flag_q <= '0;
            ch_armed_q <= '0;
        end else begin
            for (int i = 0; i < NUM_CH; i++) begin
                // Same priority as the overflow flag: event, clearing write, arming read
                if (evt.ch[i]) begin
                    channel_event_flag_q[i] <= 1'b1;
                    ch_armed_q[i] <= 1'b0;
                end else if (bus.wr && is_ch(bus.addr, OFS_CH_CTRL, i)
                             && !bus.wdata[CC_FLAG_BIT] && ch_armed_q[i]) begin
                    channel_event_flag_q[i] <= 1'b0;
                    ch_armed_q[i] <= 1'b0;
                end else if (bus.rd && is_ch(bus.addr, OFS_CH_CTRL, i)
                             && channel_event_flag_q[i]) begin
                    ch_armed_q[i] <= 1'b1;
                end
            end
        end
    end

    // Level request while any enabled flag is set
    // Decoded straight from flops, so it follows a flag or enable with no delay
    assign irq = (overflow_flag_q && overflow_irq_enable_q)
        || |(channel_event_flag_q & channel_irq_enable_q);

    // Read data registered, valid the cycle after the read strobe
    // It then holds until the next read strobe
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            reg_rdata <= 16'h0000;
        end else if (bus.rd) begin
            reg_rdata <= 16'h0000;
            case (bus.addr)
                OFS_STATUS_CONTROL: begin
                    reg_rdata[SC_RUN_BIT] <= run_q;
                    reg_rdata[SC_CENTER_BIT] <= center_aligned_select_q;
                    reg_rdata[SC_OVF_IE_BIT] <= overflow_irq_enable_q;
                    reg_rdata[SC_OVF_FLAG_BIT] <= overflow_flag_q;
                end
                OFS_MODULO: reg_rdata <= modulo_q;
                OFS_COUNT: reg_rdata <= count_q;
                // Channel words and unmapped indices; unmapped ones return zero
                default: begin
                    for (int i = 0; i < NUM_CH; i++) begin
                        if (is_ch(bus.addr, OFS_CH_CTRL, i)) begin
                            reg_rdata[CC_ELS_LO_BIT] <= edge_level_select_lo_q[i];
                            reg_rdata[CC_ELS_HI_BIT] <= edge_level_select_hi_q[i];
                            reg_rdata[CC_MODE_BIT] <= compare_mode_q[i];
                            reg_rdata[CC_IE_BIT] <= channel_irq_enable_q[i];
                            reg_rdata[CC_FLAG_BIT] <= channel_event_flag_q[i];
                        end
                        if (is_ch(bus.addr, OFS_CH_VALUE, i)) begin
                            reg_rdata <= ch_value_q[i];
                        end
                    end
                end
            endcase
        end
    end

endmodule

// >>> verification/tpf_timer_flags_monitor.sv
// Port-side checker for the timer flag block
module tpf_timer_flags_monitor
    import tpf_pkg::*;
#(
    parameter int NUM_CH = 4
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Register port
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    // Pins and request
    input wire logic [NUM_CH-1:0] capture_pin,
    input wire logic irq
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] sc_q;
    logic ran_q;
    logic [3:0] ctl_q [4];
    logic any_ie;
    logic cap0;
    // Shadow of written control fields; every field but the flag bits is mirrored
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            sc_q <= 3'h0;
            ran_q <= 1'b0;
            ctl_q <= '{default: 4'h0};
        end else if (reg_wr && reg_addr == OFS_STATUS_CONTROL) begin
            sc_q <= reg_wdata[2:0];
            ran_q <= ran_q | reg_wdata[SC_RUN_BIT];
        end else if (reg_wr && reg_addr[3:2] == 2'b01) begin
            ctl_q[reg_addr[1:0]] <= reg_wdata[3:0];
        end
    end
    // Any enable that may let a request out
    assign any_ie = sc_q[2] | ctl_q[0][3] | ctl_q[1][3] | ctl_q[2][3] | ctl_q[3][3];
    assign cap0 = ctl_q[0][3:2] == 2'b10 && !sc_q[SC_CENTER_BIT];
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    a_irq_reset: assert property ($fell(rst) |-> !irq)
        else $error("request high after reset");
    a_rdata_reset: assert property ($fell(rst) |-> reg_rdata == 16'h0000)
        else $error("read data not cleared by reset");
    a_count_stopped: assert property (reg_rd && reg_addr == OFS_COUNT && !ran_q
        |=> reg_rdata == 16'h0000) else $error("counter moved while stopped");
    a_clear_cause: assert property ($fell(irq) |-> $past(reg_wr))
        else $error("request dropped without a write");
    a_polled_quiet: assert property (!any_ie |-> !irq)
        else $error("request with all enables clear");
    a_irq_enabled: assert property ($rose(irq) |-> any_ie)
        else $error("request rose with no enable");
    a_cap_rise: assert property (cap0 && ctl_q[0][0] && $rose(capture_pin[0])
        |-> ##[1:6] irq) else $error("rising capture missed");
    a_cap_fall: assert property (cap0 && ctl_q[0][1] && $fell(capture_pin[0])
        |-> ##[1:6] irq) else $error("falling capture missed");
endmodule
bind tpf_timer_flags tpf_timer_flags_monitor #(.NUM_CH(NUM_CH)) mon_u (
    .mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .capture_pin(capture_pin), .irq(irq));

// >>> verification/tpf_irq_sink.sv
// Interrupt module model that takes the timer request
module tpf_irq_sink (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Request from the timer
    input wire logic irq,
    // Pending level and count of new requests
    output logic pending,
    output int n_req
);
    timeunit 1ns;
    timeprecision 1ps;
    // High-true level taken each cycle; a rise counts as a new request
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pending <= 1'b0;
            n_req <= 0;
        end else begin
            pending <= irq;
            if (irq && !pending) n_req <= n_req + 1;
        end
    end
endmodule

// >>> verification/tpf_timer_flags_tb_top.sv
// Self-checking bench for the timer flag block
module tpf_timer_flags_tb_top
    import tpf_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [3:0] RST_ADR [10] = '{4'h0, 4'h2, 4'h4, 4'h5, 4'h6, 4'h7, 4'h3, 4'hC,
        4'hD, 4'h2};
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [3:0] capture_pin = 4'h0;
    logic [15:0] reg_rdata, rd_v;
    logic irq, pending;
    int err_total = 0, n_checks = 0, cyc = 0, n_req, t1, n0;
    tpf_timer_flags dut_u (.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .capture_pin(capture_pin),
        .irq(irq));
    tpf_irq_sink sink_u (.mclk(mclk), .rst(rst), .irq(irq), .pending(pending), .n_req(n_req));
    initial begin
        forever #20 mclk = ~mclk;
    end
    // Cycle count doubles as the hang guard
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            err_total++;
            complete_run();
        end
    end
    task automatic complete_run();
        if (err_total == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 rd_v = reg_rdata;
    endtask
    task automatic do_reset();
        @(posedge mclk);
        rst <= 1'b1;
        repeat (5) @(posedge mclk);
        rst <= 1'b0;
        #1;
    endtask
    // Bounded wait for the request level, judged at the end
    task automatic wait_irq(input logic want);
        for (int i = 0; i < 40 && irq !== want; i++) begin
            @(posedge mclk);
            #1;
        end
        chk("irq level", irq, want);
    endtask
    // Two events apart by a known count, with a clear between them
    task automatic gap(input logic [3:0] ca, input logic [15:0] cd, input int exp);
        wait_irq(1'b1);
        t1 = cyc;
        rd(ca);
        chk("flag before clear", rd_v[CC_FLAG_BIT], 1'b1);
        wr(ca, cd);
        chk("irq after clear", irq, 1'b0);
        wait_irq(1'b1);
        chk("event spacing", 16'(cyc - t1), 16'(exp));
    endtask
    task automatic t_reset();
        do_reset();
        chk("irq after reset", irq, 1'b0);
        foreach (RST_ADR[i]) begin
            rd(RST_ADR[i]);
            chk("reset read", rd_v, 16'h0000);
        end
    endtask
    task automatic t_counts();
        do_reset();
        wr(OFS_MODULO, 16'h0005);
        wr(OFS_STATUS_CONTROL, 16'h0005);
        gap(OFS_STATUS_CONTROL, 16'h0005, 6);
        wr(OFS_COUNT, 16'h0000);
        rd(OFS_COUNT);
        chk("count restart", rd_v, 16'h0001);
        do_reset();
        wr(OFS_MODULO, 16'h0009);
        wr(4'h9, 16'h0003);
        wr(4'h5, 16'h000C);
        wr(OFS_STATUS_CONTROL, 16'h0001);
        gap(4'h5, 16'h000C, 10);
        do_reset();
        wr(OFS_MODULO, 16'h0006);
        wr(4'hA, 16'h0002);
        wr(4'h6, 16'h0008);
        wr(OFS_STATUS_CONTROL, 16'h0003);
        gap(4'h6, 16'h0008, 8);
        do_reset();
        wr(OFS_MODULO, 16'h0006);
        wr(OFS_STATUS_CONTROL, 16'h0007);
        gap(OFS_STATUS_CONTROL, 16'h0007, 12);
    endtask
    // Overflow every second cycle, so an event lands between read and write
    task automatic t_polled();
        do_reset();
        wr(OFS_MODULO, 16'h0001);
        wr(OFS_STATUS_CONTROL, 16'h0001);
        repeat (9) @(posedge mclk);
        #1;
        chk("polled irq", irq, 1'b0);
        wr(OFS_STATUS_CONTROL, 16'h0005);
        chk("write without read", irq, 1'b1);
        rd(OFS_STATUS_CONTROL);
        wr(OFS_STATUS_CONTROL, 16'h0005);
        chk("event inside clear", irq, 1'b1);
        wr(OFS_STATUS_CONTROL, 16'h0004);
        rd(OFS_STATUS_CONTROL);
        wr(OFS_STATUS_CONTROL, 16'h0004);
        chk("stopped clear", irq, 1'b0);
    endtask
    // Every edge select code, each on its own channel
    task automatic t_capture();
        for (int sel = 0; sel < 4; sel++) begin
            do_reset();
            n0 = n_req;
            wr(4'(OFS_CH_CTRL + 3 - sel), 16'(8 + sel));
            @(posedge mclk);
            capture_pin[3 - sel] <= 1'b1;
            repeat (6) @(posedge mclk);
            #1;
            chk("rising capture", irq, sel[0]);
            if (irq === 1'b1) begin
                rd(4'(OFS_CH_CTRL + 3 - sel));
                wr(4'(OFS_CH_CTRL + 3 - sel), 16'(8 + sel));
            end
            @(posedge mclk);
            capture_pin[3 - sel] <= 1'b0;
            repeat (6) @(posedge mclk);
            #1;
            chk("falling capture", irq, sel[1]);
            chk("request count", 16'(n_req - n0), 16'(sel[0]) + 16'(sel[1]));
        end
    endtask
    initial begin
        t_reset();
        t_counts();
        t_polled();
        t_capture();
        complete_run();
    end
endmodule
